// ==== logic/stcp_pkg.sv ====
// Constants, field layout and shared helper for the compare/PWM timer.
// Assumes a single core clock; imported by nothing, always used with stcp_pkg::.
//
// What this block does
// - Counter readable, low byte plus two high bits
// - Compare-A value read/write, ten bits, resets zero
// - High-byte registers read zero above bit one
// - Mode field 00 selects compare match output
// - Clear-select low: clear on P, both flags
// - Clear-select high: clear on A, A flag only
// - Compare mode: only A match moves the pin
// - A match drives pin high, low or toggles
// - Output-action 00 leaves pin unchanged on match
// - On-bit rising edge loads pin initial level
// - Mode 01 behaves as timer/counter mode
// - Timer/counter mode leaves pin undriven
// - Mode 10 is PWM, clear-select ignored
// - Swap bit exchanges period and duty sources
// - Period source match clears counter, starts period
// - Duty at or above period gives full duty
// - PWM mode sets A and P flags on matches
// - Output-control picks polarity, action enables waveform
// - Invert bit inverts the pin level
// - Forced pin keeps counting and flags running
// - Period bits compare top three counter bits
// - On-bit rise zeroes counter, fall holds it

package stcp_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam int          ADDR_W       = 3;
   localparam int          CNT_W        = 10;
   localparam logic [2:0]  ADDR_CTRL0   = 3'h0;
   localparam logic [2:0]  ADDR_CTRL1   = 3'h1;
   localparam logic [2:0]  ADDR_CNT_LO  = 3'h2;
   localparam logic [2:0]  ADDR_CNT_HI  = 3'h3;
   localparam logic [2:0]  ADDR_CMPA_LO = 3'h4;
   localparam logic [2:0]  ADDR_CMPA_HI = 3'h5;
   localparam logic [2:0]  ADDR_FLAGS   = 3'h6;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTRL0_PAUSE  = 7;
   localparam int CTRL0_CKS_HI = 6;
   localparam int CTRL0_CKS_LO = 4;
   localparam int CTRL0_ON     = 3;
   localparam int CTRL0_RP_HI  = 2;
   localparam int CTRL0_RP_LO  = 0;
   localparam int CTRL1_MODE_HI = 7;
   localparam int CTRL1_MODE_LO = 6;
   localparam int CTRL1_IO_HI  = 5;
   localparam int CTRL1_IO_LO  = 4;
   localparam int CTRL1_OC     = 3;
   localparam int CTRL1_POL    = 2;
   localparam int CTRL1_DPX    = 1;
   localparam int CTRL1_CCLR   = 0;
   localparam int FLAG_A       = 0;
   localparam int FLAG_P       = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0]       CTRL0_RST = 8'h00;
   localparam logic [7:0]       CTRL1_RST = 8'h00;
   localparam logic [CNT_W-1:0] CMPA_RST  = 10'h000;
   localparam logic [CNT_W-1:0] CNT_RST   = 10'h000;

   ////////////////////////////////////////////////////////////////////////////////
   // Encodings
   localparam logic [1:0] MODE_CMP = 2'h0;
   localparam logic [1:0] MODE_CAP = 2'h1;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] MODE_TMR = 2'h3;
   localparam logic [1:0] IO_NONE   = 2'h0;
   localparam logic [1:0] IO_LOW    = 2'h1;
   localparam logic [1:0] IO_HIGH   = 2'h2;
   localparam logic [1:0] IO_TOGGLE = 2'h3;
   localparam logic [1:0] IO_PWM_INACT = 2'h0;
   localparam logic [1:0] IO_PWM_ACT   = 2'h1;
   localparam logic [2:0] CKS_DIV4     = 3'h0;
   localparam logic [2:0] CKS_SYS      = 3'h1;
   localparam logic [2:0] CKS_DIV16    = 3'h2;
   localparam logic [2:0] CKS_DIV64    = 3'h3;
   localparam logic [2:0] CKS_BASE     = 3'h4;
   localparam logic [2:0] CKS_NONE     = 3'h5;
   localparam logic [2:0] CKS_PIN_RISE = 3'h6;
   localparam logic [2:0] CKS_PIN_FALL = 3'h7;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing counts
   localparam int         PRE_W      = 6;
   localparam logic [5:0] DIV4_LAST  = 6'h03;
   localparam logic [5:0] DIV16_LAST = 6'h0F;
   localparam logic [5:0] DIV64_LAST = 6'h3F;
   localparam logic [10:0] FULL_SPAN = 11'h400;

   // Period bits sit on counter bits 9..7; zero means full 1024 span
   function automatic logic [10:0] period_top(input logic [2:0] rp);
      period_top = (rp == 3'h0) ? FULL_SPAN : {1'b0, rp, 7'h00};
   endfunction

endpackage

// ==== logic/stcp_cmp_if.sv ====
// Bundle between the timer core and its comparator unit.
// Assumes both ends sit in the core clock domain.
`timescale 1ns/1ps

interface stcp_cmp_if;
   logic [9:0] count;
   logic [9:0] cmpA;
   logic [2:0] periodBits;
   logic       matchA;
   logic       matchP;

   modport core (output count, output cmpA, output periodBits, input matchA, input matchP);
   modport cmp  (input count, input cmpA, input periodBits, output matchA, output matchP);
endinterface

// ==== logic/stcp_match.sv ====
// Comparators A and P, judged on the value the counter is about to take.
// Assumes the core applies the result only on a timer tick.
`timescale 1ns/1ps

module stcp_match (
   stcp_cmp_if.cmp cmp
);
   wire [10:0] nextCount;

   assign nextCount  = {1'b0, cmp.count} + 11'h001;
   // Compare-A of zero never matches, software keeps it nonzero
   assign cmp.matchA = (nextCount == {1'b0, cmp.cmpA});
   assign cmp.matchP = (nextCount == stcp_pkg::period_top(cmp.periodBits));
endmodule // stcp_match

// ==== logic/stcp_timer.sv ====
// Top of the 10-bit compare/PWM timer with its register port.
// Assumes a one-cycle register strobe master on core_clk; pins are asynchronous.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps

module stcp_timer (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       clkEn,
   input  wire logic [2:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdData,
   input  wire logic       extClkPin,
   input  wire logic       baseTickPin,
   output logic            timerOut,
   output logic            timerOutEn
);

   ////////////////////////////////////////////////////////////////////////////////
   // State
   logic [7:0] ctrl0;
   logic [7:0] ctrl1;
   logic [9:0] cmpA;
   logic [9:0] count;
   logic       flagA;
   logic       flagP;
   logic       onPrev;
   logic       outLevel;
   logic [5:0] prescale;
   logic [1:0] pinSync0;
   logic [1:0] pinSync1;
   logic [1:0] pinSync2;
   logic [1:0] pinLevel;

   stcp_cmp_if cmpBus ();

   stcp_match u_match (
      .cmp (cmpBus.cmp)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode
   wire wrCtrl0  = regWr && (regAddr == stcp_pkg::ADDR_CTRL0);
   wire wrCtrl1  = regWr && (regAddr == stcp_pkg::ADDR_CTRL1);
   wire wrCmpLo  = regWr && (regAddr == stcp_pkg::ADDR_CMPA_LO);
   wire wrCmpHi  = regWr && (regAddr == stcp_pkg::ADDR_CMPA_HI);
   wire wrFlags  = regWr && (regAddr == stcp_pkg::ADDR_FLAGS);

   wire       paused    = ctrl0[stcp_pkg::CTRL0_PAUSE];
   wire [2:0] clkSel    = ctrl0[stcp_pkg::CTRL0_CKS_HI:stcp_pkg::CTRL0_CKS_LO];
   wire       timerOn   = ctrl0[stcp_pkg::CTRL0_ON];
   wire [2:0] periodBits = ctrl0[stcp_pkg::CTRL0_RP_HI:stcp_pkg::CTRL0_RP_LO];
   wire [1:0] mode      = ctrl1[stcp_pkg::CTRL1_MODE_HI:stcp_pkg::CTRL1_MODE_LO];
   wire [1:0] ioSel     = ctrl1[stcp_pkg::CTRL1_IO_HI:stcp_pkg::CTRL1_IO_LO];
   wire       initLevel = ctrl1[stcp_pkg::CTRL1_OC];
   wire       invert    = ctrl1[stcp_pkg::CTRL1_POL];
   wire       swapDp    = ctrl1[stcp_pkg::CTRL1_DPX];
   wire       clrByA    = ctrl1[stcp_pkg::CTRL1_CCLR];

   wire pwmMode  = (mode == stcp_pkg::MODE_PWM);
   wire cmpMode  = (mode == stcp_pkg::MODE_CMP);
   wire tmrMode  = (mode == stcp_pkg::MODE_TMR);
   wire onRise   = timerOn && !onPrev;

   ////////////////////////////////////////////////////////////////////////////////
   // Timer clock selection; bit 0 base tick pin, bit 1 external clock pin
   wire [1:0] pinAgree = ~(pinSync1 ^ pinSync2);
   wire [1:0] pinRise  = pinAgree & pinSync2 & ~pinLevel;
   wire [1:0] pinFall  = pinAgree & ~pinSync2 & pinLevel;
   logic tick;

   always_comb begin
      case (clkSel)
         stcp_pkg::CKS_DIV4:     tick = (prescale[1:0] == stcp_pkg::DIV4_LAST[1:0]);
         stcp_pkg::CKS_SYS:      tick = 1'b1;
         stcp_pkg::CKS_DIV16:    tick = (prescale[3:0] == stcp_pkg::DIV16_LAST[3:0]);
         stcp_pkg::CKS_DIV64:    tick = (prescale == stcp_pkg::DIV64_LAST);
         stcp_pkg::CKS_BASE:     tick = pinRise[0];
         stcp_pkg::CKS_PIN_RISE: tick = pinRise[1];
         stcp_pkg::CKS_PIN_FALL: tick = pinFall[1];
         default:                tick = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Counter, clears and flags
   assign cmpBus.count      = count;
   assign cmpBus.cmpA       = cmpA;
   assign cmpBus.periodBits = periodBits;

   wire running  = timerOn && !paused;
   wire step     = running && tick;
   // PWM uses the swap bit to choose the clearing comparator
   wire clearOnA = pwmMode ? swapDp : clrByA;
   wire clrNow   = step && (clearOnA ? cmpBus.matchA : cmpBus.matchP);
   wire setA     = step && cmpBus.matchA;
   wire setP     = step && cmpBus.matchP && (pwmMode || !clrByA);

   logic [9:0] next_count;

   always_comb begin
      if (onRise) begin
         next_count = stcp_pkg::CNT_RST;
      end else if (clrNow) begin
         next_count = stcp_pkg::CNT_RST;
      end else if (step) begin
         next_count = count + 10'h001;
      end else begin
         next_count = count;
      end
   end

   // A hardware set beats a same-cycle software clear
   wire next_flagA = setA || (flagA && !(wrFlags && regWrData[stcp_pkg::FLAG_A]));
   wire next_flagP = setP || (flagP && !(wrFlags && regWrData[stcp_pkg::FLAG_P]));

   ////////////////////////////////////////////////////////////////////////////////
   // Compare match output level
   logic next_outLevel;

   always_comb begin
      next_outLevel = outLevel;
      if (onRise) begin
         next_outLevel = initLevel;
      end else if (setA && !pwmMode) begin
         case (ioSel)
            stcp_pkg::IO_LOW:    next_outLevel = 1'b0;
            stcp_pkg::IO_HIGH:   next_outLevel = 1'b1;
            stcp_pkg::IO_TOGGLE: next_outLevel = !outLevel;
            default:             next_outLevel = outLevel;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // PWM waveform
   wire [10:0] pTop    = stcp_pkg::period_top(periodBits);
   wire [10:0] dutyV   = swapDp ? pTop : {1'b0, cmpA};
   wire [10:0] periodV = swapDp ? {1'b0, cmpA} : pTop;
   wire        pwmOn   = (dutyV >= periodV) || ({1'b0, count} < dutyV);
   logic       pwmLevel;

   always_comb begin
      case (ioSel)
         stcp_pkg::IO_PWM_INACT: pwmLevel = !initLevel;
         stcp_pkg::IO_PWM_ACT:   pwmLevel = initLevel;
         default:                pwmLevel = pwmOn ? initLevel : !initLevel;
      endcase
   end

   wire next_timerOut   = (pwmMode ? pwmLevel : outLevel) ^ invert;
   wire next_timerOutEn = cmpMode || pwmMode;

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux
   logic [7:0] rdMux;

   always_comb begin
      case (regAddr)
         stcp_pkg::ADDR_CTRL0:   rdMux = ctrl0;
         stcp_pkg::ADDR_CTRL1:   rdMux = ctrl1;
         stcp_pkg::ADDR_CNT_LO:  rdMux = count[7:0];
         stcp_pkg::ADDR_CNT_HI:  rdMux = {6'h00, count[9:8]};
         stcp_pkg::ADDR_CMPA_LO: rdMux = cmpA[7:0];
         stcp_pkg::ADDR_CMPA_HI: rdMux = {6'h00, cmpA[9:8]};
         stcp_pkg::ADDR_FLAGS:   rdMux = {6'h00, flagP, flagA};
         default:                rdMux = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrl0 <= stcp_pkg::CTRL0_RST;
         ctrl1 <= stcp_pkg::CTRL1_RST;
         cmpA  <= stcp_pkg::CMPA_RST;
      end else if (clkEn) begin
         if (wrCtrl0) begin
            ctrl0 <= regWrData;
         end
         if (wrCtrl1) begin
            ctrl1 <= regWrData;
         end
         if (wrCmpLo) begin
            cmpA[7:0] <= regWrData;
         end
         if (wrCmpHi) begin
            cmpA[9:8] <= regWrData[1:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         count    <= stcp_pkg::CNT_RST;
         flagA    <= 1'b0;
         flagP    <= 1'b0;
         onPrev   <= 1'b0;
         outLevel <= 1'b0;
         prescale <= 6'h00;
      end else if (clkEn) begin
         count    <= next_count;
         flagA    <= next_flagA;
         flagP    <= next_flagP;
         onPrev   <= timerOn;
         outLevel <= next_outLevel;
         prescale <= prescale + 6'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pinSync0 <= 2'h0;
         pinSync1 <= 2'h0;
         pinSync2 <= 2'h0;
         pinLevel <= 2'h0;
      end else if (clkEn) begin
         pinSync0 <= {extClkPin, baseTickPin};
         pinSync1 <= pinSync0;
         pinSync2 <= pinSync1;
         pinLevel <= (pinAgree & pinSync2) | (~pinAgree & pinLevel);
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         timerOut   <= 1'b0;
         timerOutEn <= 1'b0;
         regRdData  <= 8'h00;
      end else if (clkEn) begin
         timerOut   <= next_timerOut;
         timerOutEn <= next_timerOutEn;
         regRdData  <= regRd ? rdMux : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   property p_cnt_read;
      clkEn && regRd && (regAddr == stcp_pkg::ADDR_CNT_LO)
         |=> (regRdData == $past(count[7:0]));
   endproperty
   a_cnt_read: assert property (p_cnt_read)
      else $error("counter low read mismatch");

   property p_hi_zero;
      clkEn && regRd && ((regAddr == stcp_pkg::ADDR_CNT_HI) || (regAddr == stcp_pkg::ADDR_CMPA_HI))
         |=> (regRdData[7:2] == 6'h00);
   endproperty
   a_hi_zero: assert property (p_hi_zero)
      else $error("unimplemented high bits not zero");

   property p_cmpa_write;
      clkEn && wrCmpLo |=> (cmpA[7:0] == $past(regWrData));
   endproperty
   a_cmpa_write: assert property (p_cmpa_write)
      else $error("compare-A low byte not stored");

   property p_on_rise;
      clkEn && timerOn && !onPrev
         |=> (count == 10'h000) && (outLevel == $past(initLevel));
   endproperty
   a_on_rise: assert property (p_on_rise)
      else $error("on-bit rise did not restart counter and pin");

   property p_no_pflag;
      clkEn && cmpMode && clrByA && !flagP |=> !flagP;
   endproperty
   a_no_pflag: assert property (p_no_pflag)
      else $error("P flag set with clear-select high");

   property p_tmr_pin;
      clkEn && tmrMode |=> !timerOutEn;
   endproperty
   a_tmr_pin: assert property (p_tmr_pin)
      else $error("pin driven in timer mode");

   property p_full_duty;
      clkEn && pwmMode && (ioSel == stcp_pkg::IO_HIGH) && initLevel && !invert
         && (dutyV >= periodV) |=> timerOut;
   endproperty
   a_full_duty: assert property (p_full_duty)
      else $error("full duty not held high");

   property p_step;
      clkEn && step && !clrNow && !onRise |=> (count == $past(count) + 10'h001);
   endproperty
   a_step: assert property (p_step)
      else $error("counter did not advance on tick");

   property p_io_none;
      clkEn && cmpMode && (ioSel == stcp_pkg::IO_NONE) && !onRise
         |=> (outLevel == $past(outLevel));
   endproperty
   a_io_none: assert property (p_io_none)
      else $error("pin moved with output action off");

   property p_pclear;
      clkEn && cmpMode && !clrByA && step && cmpBus.matchP && !onRise
         |=> (count == 10'h000) && flagP;
   endproperty
   a_pclear: assert property (p_pclear)
      else $error("P match did not clear counter and flag");

   property p_seta_flag;
      clkEn && setA |=> flagA;
   endproperty
   a_seta_flag: assert property (p_seta_flag)
      else $error("A match did not raise its flag");

   property p_pwm_pflag;
      clkEn && pwmMode && step && cmpBus.matchP |=> flagP;
   endproperty
   a_pwm_pflag: assert property (p_pwm_pflag)
      else $error("P match in PWM did not raise its flag");

   property p_cmp_toggle;
      clkEn && cmpMode && setA && !onRise && (ioSel == stcp_pkg::IO_TOGGLE)
         |=> (outLevel != $past(outLevel));
   endproperty
   a_cmp_toggle: assert property (p_cmp_toggle)
      else $error("A match did not toggle the pin");

   property p_pwm_clear;
      clkEn && pwmMode && step && !onRise && (swapDp ? cmpBus.matchA : cmpBus.matchP)
         |=> (count == 10'h000);
   endproperty
   a_pwm_clear: assert property (p_pwm_clear)
      else $error("period match did not restart PWM counter");

   property p_freeze;
      !clkEn |=> (count == $past(count)) && (cmpA == $past(cmpA));
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved with clock enable low");

   property p_p_no_pin;
      clkEn && cmpMode && step && cmpBus.matchP && !cmpBus.matchA && !onRise
         |=> (outLevel == $past(outLevel));
   endproperty
   a_p_no_pin: assert property (p_p_no_pin)
      else $error("P match moved the compare pin");

   property p_rd_idle;
      clkEn && !regRd |=> (regRdData == 8'h00);
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not idle without a read");

endmodule // stcp_timer

// ==== dv/stcp_pin_load.sv ====
// Load hung on the timer output pin: a weak pull-down on the pad.
// Assumes the timer's pin level and output enable arrive as plain wires.
`timescale 1ns/1ps

module stcp_pin_load (
   input  wire logic pinLevel,
   input  wire logic pinDriveEn,
   output logic      padLevel
);
   ////////////////////////////////////////////////////////////////////////////////
   // Pull-down holds the pad low while the timer releases it
   assign padLevel = (pinDriveEn === 1'b1) ? pinLevel : 1'b0;
endmodule // stcp_pin_load

// ==== dv/stcp_timer_tb_top.sv ====
// Self-checking bench for the compare/PWM timer, driven over its register port.
// Assumes the pin load model and the design files are compiled first.
`timescale 1ns/1ps

module stcp_timer_tb_top;
   logic       core_clk;
   logic       reset;
   logic       clkEn;
   logic [2:0] regAddr;
   logic [7:0] regWrData;
   logic       regWr;
   logic       regRd;
   logic [7:0] regRdData;
   logic       extClkPin;
   logic       baseTickPin;
   logic       timerOut;
   logic       timerOutEn;
   logic       padLevel;
   int         n_mismatch = 0;
   int         total_checks = 0;
   logic [7:0] rd;
   logic [7:0] held;
   int         n;
   logic [7:0] pc1 [7] = '{8'hA8, 8'hA9, 8'hAC, 8'hA0, 8'h88, 8'h98, 8'hAA};
   int         phi [7] = '{32, 32, 96, 96, 0, 128, 128};
   logic [7:0] pfl [7] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h01};
   logic [7:0] cio [3] = '{8'h18, 8'h08, 8'h20};
   logic [7:0] cini [3] = '{8'h01, 8'h01, 8'h00};
   logic [7:0] caft [3] = '{8'h00, 8'h01, 8'h01};

   stcp_timer u_stcp_timer (
      .core_clk    (core_clk),
      .reset       (reset),
      .clkEn       (clkEn),
      .regAddr     (regAddr),
      .regWrData   (regWrData),
      .regWr       (regWr),
      .regRd       (regRd),
      .regRdData   (regRdData),
      .extClkPin   (extClkPin),
      .baseTickPin (baseTickPin),
      .timerOut    (timerOut),
      .timerOutEn  (timerOutEn)
   );

   stcp_pin_load u_stcp_pin_load (
      .pinLevel   (timerOut),
      .pinDriveEn (timerOutEn),
      .padLevel   (padLevel)
   );

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regWr     <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask

   task automatic rdv(input logic [2:0] a);
      @(posedge core_clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      @(negedge core_clk);
      rd = regRdData;
   endtask

   task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
      rdv(a);
      check({8'h00, rd}, {8'h00, exp});
   endtask

   // Compare-A kept nonzero throughout
   task automatic cmpa(input logic [9:0] v);
      wr(3'h4, v[7:0]);
      wr(3'h5, {6'h00, v[9:8]});
   endtask

   // Off, mode change, flags cleared, then on
   task automatic cfg(input logic [7:0] c1, input logic [7:0] c0);
      wr(3'h0, c0 & 8'hF7);
      wr(3'h1, c1);
      wr(3'h6, 8'h03);
      wr(3'h0, c0);
   endtask

   // Cycles between two pin changes
   task automatic gap(output int g);
      logic l;
      int   i;
      i = 0;
      @(negedge core_clk);
      l = padLevel;
      while (padLevel === l && i < 2000) begin
         @(negedge core_clk);
         i++;
      end
      l = padLevel;
      g = 0;
      while (padLevel === l && g < 2000) begin
         @(negedge core_clk);
         g++;
      end
   endtask

   task automatic hi_cnt(output int h);
      h = 0;
      repeat (128) begin
         @(negedge core_clk);
         h += int'(padLevel === 1'b1);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      reset       = 1'b1;
      clkEn       = 1'b1;
      regAddr     = 3'h0;
      regWrData   = 8'h00;
      regWr       = 1'b0;
      regRd       = 1'b0;
      extClkPin   = 1'b0;
      baseTickPin = 1'b0;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      rdc(3'h2, 8'h00);
      rdc(3'h3, 8'h00);
      rdc(3'h4, 8'h00);
      rdc(3'h5, 8'h00);
      wr(3'h4, 8'hA5);
      wr(3'h5, 8'hFF);
      rdc(3'h4, 8'hA5);
      rdc(3'h5, 8'h03);
      rdc(3'h7, 8'h00);
      cmpa(10'h0C8);
      cfg(8'h31, 8'h19);
      gap(n);
      check(16'(n), 16'h00C8);
      rdc(3'h6, 8'h01);
      cmpa(10'h032);
      cfg(8'h30, 8'h19);
      gap(n);
      check(16'(n), 16'h0080);
      rdc(3'h6, 8'h03);
      rdc(3'h3, 8'h00);
      rdv(3'h2);
      check({15'h0000, rd[7]}, 16'h0000);
      wr(3'h0, 8'h11);
      rdv(3'h2);
      held = rd;
      repeat (10) @(negedge core_clk);
      rdc(3'h2, held);
      wr(3'h2, ~held);
      rdc(3'h2, held);
      wr(3'h0, 8'h99);
      rdc(3'h2, 8'h00);
      cmpa(10'h00A);
      for (int k = 0; k < 3; k++) begin
         cfg(cio[k], 8'h19);
         repeat (3) @(negedge core_clk);
         check({15'h0000, padLevel}, {8'h00, cini[k]});
         repeat (20) @(negedge core_clk);
         check({15'h0000, padLevel}, {8'h00, caft[k]});
      end
      cfg(8'hC1, 8'h19);
      repeat (30) @(negedge core_clk);
      check({15'h0000, timerOutEn}, 16'h0000);
      check({15'h0000, padLevel}, 16'h0000);
      rdc(3'h6, 8'h01);
      for (int k = 0; k < 7; k++) begin
         cmpa((k == 6) ? 10'h040 : 10'h020);
         cfg(pc1[k], 8'h19);
         repeat (130) @(negedge core_clk);
         hi_cnt(n);
         check(16'(n), 16'(phi[k]));
         rdc(3'h6, pfl[k]);
      end
      // Timer mode clocked by external pin rising edges
      cfg(8'hC1, 8'h68);
      repeat (5) begin
         extClkPin <= 1'b1;
         repeat (4) @(posedge core_clk);
         extClkPin <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
      repeat (8) @(posedge core_clk);
      rdc(3'h2, 8'h05);
      // Writes while clock enable is low are lost
      @(posedge core_clk);
      clkEn <= 1'b0;
      wr(3'h0, 8'h19);
      wr(3'h4, 8'h77);
      clkEn <= 1'b1;
      rdc(3'h2, 8'h05);
      rdc(3'h4, 8'h40);
      conclude();
   end

   initial begin
      repeat (60000) @(posedge core_clk);
      n_mismatch++;
      conclude();
   end
endmodule // stcp_timer_tb_top
